// *** design/qpd_decoder.sv ***
// Behaviour
// - Count up on phase pair 10->11, 00->10, 11->01, 01->00.
// - Count down on phase pair 01->11, 11->10, 00->01, 10->00.
// - Unchanged phase pair gives no count and keeps direction.
// - Both phases changing at once is ignored: no count, no direction change.
// - Decoder logic feeds an up/down position counter.
// - Every valid phase change counts, four counts per encoder cycle.
// - Direction is stored and updated only when a change is detected.
// - Count pulses carry a direction; direction is readable as status.
// - Every input passes a software-programmable digital noise filter.
// - Four inputs: phase A, phase B, index pulse, home pulse.
// - Index pulse can reset the position counter.
// - General-purpose 32-bit timer mode independent of decoding.
// - A 32-bit register initialises and captures the position.
// - 32-bit less-than and greater-than compare against position.
// - Decoder and counter events raise an interrupt request.
// - External up/down mode: external signal gives the direction.
// - External gated count mode counts only while gate is active.
// - External gated timer mode advances on clock only while gate active.
// - Disable bit 10 of module-disable register: 1 disables, 0 enables, resets 0.
`timescale 1ns/1ns
module qpd_decoder
(
    input  wire logic                       mclk,             // 100 MHz clock
    input  wire logic                       reset,            // Async reset, high
    input  wire logic                       wb_cyc_i,         // Bus cycle
    input  wire logic                       wb_stb_i,         // Strobe
    input  wire logic                       wb_we_i,          // Write enable
    input  wire logic [qpd_pkg::ADR_W-1:0]  wb_adr_i,         // Byte address
    input  wire logic [qpd_pkg::SEL_W-1:0]  wb_sel_i,         // Byte lanes
    input  wire logic [qpd_pkg::DAT_W-1:0]  wb_dat_i,         // Write data
    output wire logic [qpd_pkg::DAT_W-1:0]  wb_dat_o,         // Read data
    output wire logic                       wb_ack_o,         // Acknowledge
    input  wire logic                       phaseAInput,      // Encoder phase A pin
    input  wire logic                       phaseBInput,      // Encoder phase B pin
    input  wire logic                       indexPulseInput,  // Index pin
    input  wire logic                       homePulseInput,   // Home pin, also gate
    output wire logic                       countDir,         // 1 = counting up
    output wire logic                       eventIrq          // Masked event request
);
    import qpd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Quadrature step: {valid, up}
    function automatic logic [1:0] quadStep(input logic [1:0] prevAB, input logic [1:0] curAB);
        logic [1:0] res;
        res = 2'b00;
        case ({prevAB, curAB})
            4'b1011, 4'b0010, 4'b1101, 4'b0100: res = 2'b11;
            4'b0111, 4'b1110, 4'b0001, 4'b1000: res = 2'b10;
            default:                            res = 2'b00;
        endcase
        return res;
    endfunction

    // Byte-lane merge of a write
    function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int k = 0; k < 4; k++)
        begin
            if (sel[k])
            begin
                res[8*k +: 8] = wd[8*k +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [IN_N-1:0]    pinRaw;
    logic [SYNC_N-1:0]  sync_r [IN_N];
    logic [IN_N-1:0]    stable_r;
    logic [IN_N-1:0]    filt_r;
    logic [FILT_W-1:0]  filtCnt_r [IN_N];
    logic [IN_N-1:0]    prevIn_r;
    logic [15:0]        ctrl_r;
    logic [15:0]        disReg_r;
    logic [31:0]        pos_r;
    logic [31:0]        initCap_r;
    logic [31:0]        cmpLt_r;
    logic [31:0]        cmpGt_r;
    logic [31:0]        idxCnt_r;
    logic [EV_N-1:0]    flags_r;
    logic [EV_N-1:0]    flags_nxt;
    logic               dir_r;
    logic               irq_r;
    logic               ack_r;
    logic [31:0]        rdat_r;
    logic [31:0]        rdMux;
    logic               disabled;
    logic [2:0]         mode;
    logic [FILT_W-1:0]  filtLen;
    logic [1:0]         prevAB;
    logic [1:0]         curAB;
    logic [1:0]         step;
    logic               phaseErr;
    logic               aRise;
    logic               idxRise;
    logic               idxLoad;
    logic               cntStep;
    logic               cntUp;
    logic               busReq;
    logic               mapped;
    logic               wrAny;
    logic               regWr;
    logic               posWr;
    logic [31:0]        ctrlWide;
    logic [31:0]        disWide;

    ////////////////////////////////////////////////////////////////////////////
    // Field decode
    assign disabled = disReg_r[DIS_BIT];
    assign mode     = ctrl_r[CTRL_MODE_LSB +: 3];
    assign filtLen  = ctrl_r[CTRL_FILT_LSB +: FILT_W];
    assign pinRaw   = {homePulseInput, indexPulseInput, phaseBInput, phaseAInput};

    ////////////////////////////////////////////////////////////////////////////
    // Three-stage sync; a level is taken once stages two and three agree
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < IN_N; i++)
            begin
                sync_r[i] <= '0;
            end
            stable_r <= '0;
        end
        else
        begin
            for (int i = 0; i < IN_N; i++)
            begin
                sync_r[i] <= {sync_r[i][SYNC_N-2:0], pinRaw[i]};
                if (sync_r[i][1] == sync_r[i][2])
                begin
                    stable_r[i] <= sync_r[i][2];
                end
            end
        end
    end

    // Noise filter: output follows after filtLen+1 stable cycles
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < IN_N; i++)
            begin
                filtCnt_r[i] <= '0;
            end
            filt_r   <= '0;
            prevIn_r <= '0;
        end
        else if (disabled)
        begin
            for (int i = 0; i < IN_N; i++)
            begin
                filtCnt_r[i] <= '0;
            end
            filt_r   <= stable_r;  // Track pins, no false step on enable
            prevIn_r <= stable_r;
        end
        else
        begin
            prevIn_r <= filt_r;
            for (int i = 0; i < IN_N; i++)
            begin
                if (stable_r[i] == filt_r[i])
                begin
                    filtCnt_r[i] <= '0;
                end
                else if (filtCnt_r[i] >= filtLen)
                begin
                    filt_r[i]    <= stable_r[i];
                    filtCnt_r[i] <= '0;
                end
                else
                begin
                    filtCnt_r[i] <= filtCnt_r[i] + 4'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoder and count source selection
    assign prevAB   = {prevIn_r[IN_A], prevIn_r[IN_B]};
    assign curAB    = {filt_r[IN_A], filt_r[IN_B]};
    assign step     = quadStep(prevAB, curAB);
    assign phaseErr = (prevAB ^ curAB) == 2'b11;
    assign aRise    = filt_r[IN_A] & ~prevIn_r[IN_A];
    assign idxRise  = filt_r[IN_IDX] & ~prevIn_r[IN_IDX];
    assign idxLoad  = idxRise & ctrl_r[CTRL_IDXRST];

    always_comb
    begin
        cntStep = 1'b0;
        cntUp   = 1'b1;
        case (mode)
            MODE_QUAD:
            begin
                cntStep = step[1];
                cntUp   = step[0];
            end
            MODE_EXT_UD:
            begin
                cntStep = aRise;
                cntUp   = filt_r[IN_B];
            end
            MODE_TIMER:
            begin
                cntStep = 1'b1;
            end
            MODE_GATED_CNT:
            begin
                cntStep = step[1] & filt_r[IN_HOME];
                cntUp   = step[0];
            end
            MODE_GATED_TMR:
            begin
                cntStep = filt_r[IN_HOME];
            end
            default:
            begin
                cntStep = 1'b0;
                cntUp   = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign busReq = wb_cyc_i & wb_stb_i & ~ack_r;
    assign mapped = wb_adr_i[7:5] == 3'b000 && wb_adr_i[1:0] == 2'b00;
    assign wrAny  = busReq & wb_we_i & mapped;
    assign regWr  = wrAny & ~disabled;
    assign posWr  = regWr && wb_adr_i == OFS_POS;

    // Byte-lane merges for the 16-bit registers
    assign ctrlWide = laneMerge({16'h0000, ctrl_r}, wb_dat_i, wb_sel_i);
    assign disWide  = laneMerge({16'h0000, disReg_r}, wb_dat_i, wb_sel_i);

    // Direction store, changes only with a counted step; cleared while disabled
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            dir_r <= 1'b0;
        end
        else if (disabled)
        begin
            dir_r <= 1'b0;
        end
        else if (cntStep && cntUp != dir_r)
        begin
            dir_r <= cntUp;
        end
    end

    // Position counter: index load, then software write, then counting
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            pos_r <= WORD_ZERO;
        end
        else if (disabled)
        begin
            pos_r <= WORD_ZERO;
        end
        else if (idxLoad)
        begin
            pos_r <= ctrl_r[CTRL_IDXINIT] ? initCap_r : WORD_ZERO;
        end
        else if (posWr)
        begin
            pos_r <= laneMerge(pos_r, wb_dat_i, wb_sel_i);
        end
        else if (cntStep)
        begin
            pos_r <= cntUp ? pos_r + WORD_ONE : pos_r - WORD_ONE;
        end
    end

    // Init/capture register
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            initCap_r <= WORD_ZERO;
        end
        else if (!disabled && idxRise && ctrl_r[CTRL_IDXCAP])
        begin
            initCap_r <= pos_r;
        end
        else if (regWr && wb_adr_i == OFS_INITCAP)
        begin
            initCap_r <= laneMerge(initCap_r, wb_dat_i, wb_sel_i);
        end
    end

    // Index pulse counter
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            idxCnt_r <= WORD_ZERO;
        end
        else if (disabled)
        begin
            idxCnt_r <= WORD_ZERO;
        end
        else if (idxRise)
        begin
            idxCnt_r <= idxCnt_r + WORD_ONE;
        end
        else if (regWr && wb_adr_i == OFS_IDXCNT)
        begin
            idxCnt_r <= laneMerge(idxCnt_r, wb_dat_i, wb_sel_i);
        end
    end

    // Configuration registers
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            ctrl_r  <= CTRL_RST;
            cmpLt_r <= WORD_ZERO;
            cmpGt_r <= WORD_ZERO;
        end
        else if (regWr)
        begin
            case (wb_adr_i)
                OFS_CTRL:  ctrl_r  <= ctrlWide[15:0];
                OFS_CMPLT: cmpLt_r <= laneMerge(cmpLt_r, wb_dat_i, wb_sel_i);
                OFS_CMPGT: cmpGt_r <= laneMerge(cmpGt_r, wb_dat_i, wb_sel_i);
                default:   ctrl_r  <= ctrl_r;
            endcase
        end
    end

    // Module-disable register, writable even while disabled
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            disReg_r <= DIS_RST;
        end
        else if (wrAny && wb_adr_i == OFS_DISABLE)
        begin
            disReg_r <= disWide[15:0] & DIS_WRMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky events, set wins over write-1 clear
    always_comb
    begin
        flags_nxt = flags_r;
        if (regWr && wb_adr_i == OFS_STAT && wb_sel_i[0])
        begin
            flags_nxt = flags_nxt & ~wb_dat_i[EV_N-1:0];
        end
        flags_nxt[EV_LT]   = flags_nxt[EV_LT]   | ($signed(pos_r) < $signed(cmpLt_r));
        flags_nxt[EV_GT]   = flags_nxt[EV_GT]   | ($signed(pos_r) > $signed(cmpGt_r));
        flags_nxt[EV_IDX]  = flags_nxt[EV_IDX]  | idxRise;
        flags_nxt[EV_PERR] = flags_nxt[EV_PERR] | (phaseErr && (mode == MODE_QUAD || mode == MODE_GATED_CNT));
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            flags_r <= '0;
            irq_r   <= 1'b0;
        end
        else if (disabled)
        begin
            flags_r <= '0;
            irq_r   <= 1'b0;
        end
        else
        begin
            flags_r <= flags_nxt;
            irq_r   <= |(flags_r & ctrl_r[CTRL_MASK_LSB +: EV_N]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb
    begin
        rdMux = WORD_ZERO;
        if (mapped)
        begin
            case (wb_adr_i)
                OFS_CTRL:    rdMux = {16'h0000, ctrl_r};
                OFS_STAT:    rdMux = {23'h00_0000, filt_r, dir_r, flags_r};
                OFS_POS:     rdMux = pos_r;
                OFS_INITCAP: rdMux = initCap_r;
                OFS_CMPLT:   rdMux = cmpLt_r;
                OFS_CMPGT:   rdMux = cmpGt_r;
                OFS_IDXCNT:  rdMux = idxCnt_r;
                OFS_DISABLE: rdMux = {16'h0000, disReg_r};
                default:     rdMux = WORD_ZERO;
            endcase
        end
    end

    // Single-wait-state acknowledge; unmapped reads give zero
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            ack_r  <= 1'b0;
            rdat_r <= WORD_ZERO;
        end
        else
        begin
            ack_r <= busReq;
            if (busReq && !wb_we_i)
            begin
                rdat_r <= rdMux;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    assign countDir = dir_r;
    assign eventIrq = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    AST_UP_COUNT: assert property (mode == MODE_QUAD && !disabled && step == 2'b11 && !idxLoad && !posWr
        |=> pos_r == $past(pos_r) + WORD_ONE && dir_r) else $error("up transition not counted");
    AST_DOWN_COUNT: assert property (mode == MODE_QUAD && !disabled && step == 2'b10 && !idxLoad && !posWr
        |=> pos_r == $past(pos_r) - WORD_ONE && !dir_r) else $error("down transition not counted");
    AST_SAME_PAIR: assert property (mode == MODE_QUAD && !disabled && prevAB == curAB && !idxLoad && !posWr
        |=> $stable(pos_r) && $stable(dir_r)) else $error("count on unchanged phases");
    AST_INVALID: assert property (mode == MODE_QUAD && !disabled && phaseErr && !idxLoad && !posWr
        |=> $stable(pos_r) && $stable(dir_r) && flags_r[EV_PERR]) else $error("invalid transition counted");
    AST_DIR_HOLD: assert property (!disabled && !cntStep |=> $stable(dir_r))
        else $error("direction moved without a count");
    AST_SYNC_AGREE: assert property ($changed(stable_r[IN_A]) |-> $past(sync_r[IN_A][1]) == $past(sync_r[IN_A][2]))
        else $error("phase A taken before stages agreed");
    AST_FILT_PASS: assert property (!disabled && filtLen == 4'h0 && stable_r[IN_B] != filt_r[IN_B] && !disReg_r[DIS_BIT]
        ##1 !disabled |-> filt_r[IN_B] == $past(stable_r[IN_B])) else $error("filter did not follow");
    AST_INDEX_RST: assert property (!disabled && idxLoad && !ctrl_r[CTRL_IDXINIT] |=> pos_r == WORD_ZERO)
        else $error("index did not reset position");
    AST_GATED: assert property (mode == MODE_GATED_CNT && !disabled && !filt_r[IN_HOME] && !idxLoad && !posWr
        |=> $stable(pos_r)) else $error("gated count moved while gate low");
    AST_TIMER: assert property (mode == MODE_TIMER && !disabled && !idxLoad && !posWr
        |=> pos_r == $past(pos_r) + WORD_ONE) else $error("timer did not advance");
    AST_CMP_GT: assert property (!disabled && $signed(pos_r) > $signed(cmpGt_r) ##1 !disabled
        |-> flags_r[EV_GT]) else $error("greater-than event missed");
    AST_DISABLED: assert property (disabled |=> pos_r == WORD_ZERO && flags_r == '0 && !irq_r)
        else $error("disabled unit not held in reset");
    AST_BUS_ACK: assert property (busReq |=> wb_ack_o ##1 !wb_ack_o)
        else $error("acknowledge timing wrong");

    COV_UP: cover property (mode == MODE_QUAD && step == 2'b11 ##1 step == 2'b11);
    COV_DOWN: cover property (mode == MODE_QUAD && step == 2'b10);
    COV_INDEX: cover property (idxLoad && !disabled);
    COV_IRQ: cover property (!eventIrq ##1 eventIrq);

endmodule

// *** design/qpd_pkg.sv ***
package qpd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int unsigned ADR_W  = 8;
    localparam int unsigned DAT_W  = 32;
    localparam int unsigned SEL_W  = 4;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;  // Mode, index options, filter, mask
    localparam logic [7:0] OFS_STAT    = 8'h04;  // Event flags (write 1 to clear), levels
    localparam logic [7:0] OFS_POS     = 8'h08;  // Position counter
    localparam logic [7:0] OFS_INITCAP = 8'h0C;  // Position init / capture
    localparam logic [7:0] OFS_CMPLT   = 8'h10;  // Less-than compare
    localparam logic [7:0] OFS_CMPGT   = 8'h14;  // Greater-than compare
    localparam logic [7:0] OFS_IDXCNT  = 8'h18;  // Index pulse counter
    localparam logic [7:0] OFS_DISABLE = 8'h1C;  // slave_peripheral_disable_one

    ////////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int unsigned CTRL_MODE_LSB = 0;   // Mode, 3 bits
    localparam int unsigned CTRL_IDXRST   = 3;   // Index resets/loads position
    localparam int unsigned CTRL_IDXCAP   = 4;   // Index captures position
    localparam int unsigned CTRL_IDXINIT  = 5;   // Index loads init value, not zero
    localparam int unsigned CTRL_FILT_LSB = 8;   // Filter length, 4 bits
    localparam int unsigned CTRL_MASK_LSB = 12;  // Event mask, 4 bits
    localparam logic [15:0] CTRL_RST      = 16'h0000;

    // Count modes
    localparam logic [2:0] MODE_QUAD      = 3'h0;  // Quadrature 4x
    localparam logic [2:0] MODE_EXT_UD    = 3'h1;  // Phase A counts, phase B is direction
    localparam logic [2:0] MODE_TIMER     = 3'h2;  // Free 32-bit timer
    localparam logic [2:0] MODE_GATED_CNT = 3'h3;  // Quadrature while home is high
    localparam logic [2:0] MODE_GATED_TMR = 3'h4;  // Timer while home is high

    // Event flag positions
    localparam int unsigned EV_LT   = 0;  // Position below less-than compare
    localparam int unsigned EV_GT   = 1;  // Position above greater-than compare
    localparam int unsigned EV_IDX  = 2;  // Index pulse seen
    localparam int unsigned EV_PERR = 3;  // Invalid phase transition
    localparam int unsigned EV_N    = 4;

    // Input channel positions
    localparam int unsigned IN_A    = 0;
    localparam int unsigned IN_B    = 1;
    localparam int unsigned IN_IDX  = 2;
    localparam int unsigned IN_HOME = 3;
    localparam int unsigned IN_N    = 4;

    // Filter and synchroniser
    localparam int unsigned SYNC_N  = 3;
    localparam int unsigned FILT_W  = 4;

    // Module-disable register
    localparam int unsigned DIS_BIT    = 10;
    localparam logic [15:0] DIS_WRMASK = 16'h0EA9;  // Implemented bits 11,10,9,7,5,3,0
    localparam logic [15:0] DIS_RST    = 16'h0000;

    localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
    localparam logic [31:0] WORD_ONE   = 32'h0000_0001;

endpackage

// *** dv/qpd_encoder_model.sv ***
`timescale 1ns/1ns
module qpd_encoder_model
(
    input  wire logic       mclk,     // Clock
    input  wire logic [1:0] stepCmd,  // 1 up, 2 down, 3 both flip
    input  wire logic       idxCmd,   // Index level wanted
    output logic            phaseA,   // Phase A pin
    output logic            phaseB,   // Phase B pin
    output logic            index,    // Index pin
    output logic            home      // Home pin, held low
);
    initial {phaseA, phaseB, index, home} = 4'h0;
    // Gray steps move one phase at a time
    always @(posedge mclk)
    begin
        case (stepCmd)
            2'h1: {phaseA, phaseB} <= {~phaseB, phaseA};
            2'h2: {phaseA, phaseB} <= {phaseB, ~phaseA};
            2'h3: {phaseA, phaseB} <= {~phaseA, ~phaseB};
            default: ;
        endcase
        index <= idxCmd;
    end
endmodule

// *** dv/tb_quadrature_position_decoder.sv ***
`timescale 1ns/1ns
module tb_quadrature_position_decoder;
    import qpd_pkg::*;
    logic        mclk, reset, cyc, stb, we, ack, dir, irq, pa, pb, ix, hm, idxCmd;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, rd;
    logic [1:0]  stepCmd;
    int          bad_count, n_checks;
    qpd_decoder qpd_decoder_i (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .phaseAInput(pa),
        .phaseBInput(pb), .indexPulseInput(ix), .homePulseInput(hm), .countDir(dir), .eventIrq(irq));
    qpd_encoder_model qpd_encoder_model_i (.mclk(mclk), .stepCmd(stepCmd), .idxCmd(idxCmd),
        .phaseA(pa), .phaseB(pb), .index(ix), .home(hm));
    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %0t %s", $time, msg);
        end
    endtask
    // One classic Wishbone cycle, waits for ack under a bound
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (ack !== 1'b1 && k < 20);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk);
        if (k >= 20)
        begin
            bad_count++;
            $display("mismatch %0t bus timeout", $time);
            final_report();
        end
    endtask
    task automatic step(input logic [1:0] c, input int n);
        repeat (n)
        begin
            stepCmd <= c;
            @(posedge mclk);
            stepCmd <= 2'h0;
            repeat (8) @(posedge mclk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic s_reset();
        bus(1'b0, OFS_CTRL, WORD_ZERO);
        check(rd, WORD_ZERO, "ctrl reset");
        bus(1'b0, OFS_DISABLE, WORD_ZERO);
        check(rd, WORD_ZERO, "disable reset");
    endtask
    task automatic s_updown();
        step(2'h1, 4);
        bus(1'b0, OFS_POS, WORD_ZERO);
        check(rd, 32'h0000_0004, "four up counts");
        check({31'h0, dir}, WORD_ONE, "dir up");
        step(2'h2, 5);
        bus(1'b0, OFS_POS, WORD_ZERO);
        check(rd, 32'hFFFF_FFFF, "five down counts");
        check({31'h0, dir}, WORD_ZERO, "dir down");
    endtask
    task automatic s_invalid();
        step(2'h3, 1);
        bus(1'b0, OFS_POS, WORD_ZERO);
        check(rd, 32'hFFFF_FFFF, "jump ignored");
        check({31'h0, dir}, WORD_ZERO, "dir kept");
        bus(1'b0, OFS_STAT, WORD_ZERO);
        check({31'h0, rd[EV_PERR]}, WORD_ONE, "error flag");
        bus(1'b1, OFS_CTRL, 32'h0000_8000);
        check({31'h0, irq}, WORD_ONE, "masked error raises request");
        bus(1'b1, OFS_STAT, 32'h0000_0008);
        check({31'h0, irq}, WORD_ZERO, "request drops after clear");
    endtask
    task automatic s_index();
        bus(1'b1, OFS_CTRL, 32'h0000_0008);
        step(2'h1, 2);
        idxCmd <= 1'b1;
        repeat (10) @(posedge mclk);
        idxCmd <= 1'b0;
        repeat (10) @(posedge mclk);
        bus(1'b0, OFS_POS, WORD_ZERO);
        check(rd, WORD_ZERO, "index reset");
    endtask
    task automatic s_disable();
        bus(1'b1, OFS_DISABLE, 32'h0000_0400);
        bus(1'b0, OFS_DISABLE, WORD_ZERO);
        check(rd, 32'h0000_0400, "disable bit");
        bus(1'b1, OFS_POS, 32'h0000_0005);
        bus(1'b0, OFS_POS, WORD_ZERO);
        check(rd, WORD_ZERO, "write ignored");
        bus(1'b1, OFS_CMPLT, 32'h0000_0005);
        bus(1'b0, OFS_CMPLT, WORD_ZERO);
        check(rd, WORD_ZERO, "config write ignored");
        bus(1'b0, 8'h20, WORD_ZERO);
        check(rd, WORD_ZERO, "unmapped read");
        bus(1'b1, OFS_DISABLE, WORD_ZERO);
    endtask
    task automatic s_timer();
        bus(1'b1, OFS_CTRL, {29'h0, MODE_TIMER});
        bus(1'b0, OFS_POS, WORD_ZERO);
        check(rd, 32'h0000_0002, "timer counts every clock");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        {reset, cyc, stb, we, idxCmd, stepCmd, adr, sel, wdat} = {1'b1, 50'h0};
        sel = 4'hF;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        s_reset();
        s_updown();
        s_invalid();
        s_index();
        s_disable();
        s_timer();
        final_report();
    end
endmodule
